// >>> hw/ris_pkg.sv
package ris_pkg;

  // Register byte addresses; the printed offsets are indices.
  localparam logic [7:0]  IDX_STATUS_PIN_EDGE_RATE    = 8'h31;
  localparam logic [7:0]  IDX_REFERENCE_INPUT_CONFIG  = 8'h32;
  localparam logic [9:0]  ADDR_STATUS_PIN_EDGE_RATE   = {IDX_STATUS_PIN_EDGE_RATE, 2'b00};
  localparam logic [9:0]  ADDR_REFERENCE_INPUT_CONFIG = {IDX_REFERENCE_INPUT_CONFIG, 2'b00};
  localparam logic [9:0]  ADDR_REFERENCE_STATUS       = 10'h0_0D4;

  // Field positions.
  localparam int FIRST_EDGE_LSB  = 0;
  localparam int SECOND_EDGE_LSB = 2;
  localparam int SEL_LSB         = 0;
  localparam int RSVD_LSB        = 2;
  localparam int PRI_BUF_LSB     = 4;
  localparam int SEC_BUF_LSB     = 6;

  // Reset values.
  localparam logic [1:0] EDGE_RESET    = 2'h0;
  localparam logic [1:0] SEC_BUF_RESET = 2'h2;
  localparam logic [1:0] PRI_BUF_RESET = 2'h1;
  localparam logic [1:0] RSVD_RESET    = 2'h1;
  localparam logic [1:0] SEL_RESET     = 2'h1;

  // Edge rate codes.
  localparam logic [1:0] EDGE_FAST = 2'h0;
  localparam logic [1:0] EDGE_SLOW = 2'h2;

  // Buffer type codes.
  localparam logic [1:0] BUF_SINGLE  = 2'h0;
  localparam logic [1:0] BUF_DIFF    = 2'h1;
  localparam logic [1:0] BUF_CRYSTAL = 2'h2;
  localparam logic [1:0] BUF_OFF     = 2'h3;

  // Reference select codes.
  localparam logic [1:0] SEL_AUTO    = 2'h0;
  localparam logic [1:0] SEL_PIN     = 2'h1;
  localparam logic [1:0] SEL_PRIMARY = 2'h2;
  localparam logic [1:0] SEL_SECOND  = 2'h3;

  // Three-level pin levels.
  localparam logic [1:0] PIN_LOW  = 2'h0;
  localparam logic [1:0] PIN_MID  = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;

  // Resolved reference choice.
  typedef enum logic [2:0] {
    RIS_REF_AUTO    = 3'b001,
    RIS_REF_PRIMARY = 3'b010,
    RIS_REF_SECOND  = 3'b100
  } ris_ref_e;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

endpackage : ris_pkg

// >>> hw/ris_ref_decode.sv
`timescale 1ns/10ps
module ris_ref_decode
  import ris_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       reset,
  // Selection inputs.
  input  wire logic [1:0] sel_code,
  input  wire logic [1:0] pin_level,
  // Registered choice.
  output ris_ref_e        ref_choice_q
);

  ris_ref_e ref_choice_d;

  always_comb
  begin
    case (sel_code)
      SEL_AUTO:    ref_choice_d = RIS_REF_AUTO;
      SEL_PRIMARY: ref_choice_d = RIS_REF_PRIMARY;
      SEL_SECOND:  ref_choice_d = RIS_REF_SECOND;
      default:
      begin
        // Pin is consulted only in pin-controlled mode.
        if (pin_level == PIN_LOW)
          ref_choice_d = RIS_REF_PRIMARY;
        else if (pin_level == PIN_MID)
          ref_choice_d = RIS_REF_SECOND;
        else
          ref_choice_d = RIS_REF_AUTO;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      ref_choice_q <= RIS_REF_AUTO;
    else
      ref_choice_q <= ref_choice_d;
  end

endmodule // ris_ref_decode

// >>> hw/ris_regs.sv
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
// Overview of operation
// - Second pin edge: 0 fast, 2 slow
// - First pin edge bits 1:0, reset 0
// - Secondary buffer bits 7:6, reset crystal
// - Primary buffer bits 5:4, reset differential
// - Reference select bits 1:0, reset pin
// - Pin used only in pin-controlled mode
// - Pin low primary, mid secondary, high auto
module ris_regs
  import ris_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Three-level reference choice pin, already resolved to a level code.
  input  wire logic [1:0]  reference_choice_pin,
  // Pin and buffer controls.
  output logic      [1:0]  first_status_edge_rate,
  output logic      [1:0]  second_status_edge_rate,
  output logic             first_status_slow,
  output logic             second_status_slow,
  output logic      [1:0]  primary_buffer_type,
  output logic      [1:0]  secondary_buffer_type,
  output logic      [1:0]  synth_reference_select,
  output logic      [2:0]  synth_reference_choice
);

  logic [1:0]  first_edge_q;
  logic [1:0]  second_edge_q;
  logic [1:0]  sec_buf_q;
  logic [1:0]  pri_buf_q;
  logic [1:0]  rsvd_q;
  logic [1:0]  sel_q;
  logic        wr_pend_q;
  logic [9:0]  wr_addr_q;
  logic [31:0] hrdata_q;
  ris_ref_e    choice_q;

  wire logic   take = hsel && hready && (htrans == HTRANS_NONSEQ);

  function automatic logic edge_is_slow(input logic [1:0] code);
    edge_is_slow = (code == EDGE_SLOW);
  endfunction

  // Captures a write address phase for the following data phase.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 10'h0_000;
    end
    else
    begin
      wr_pend_q <= take && hwrite;
      if (take)
        wr_addr_q <= haddr[9:0];
    end
  end

  // Register writes during the data phase.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      first_edge_q  <= EDGE_RESET;
      second_edge_q <= EDGE_RESET;
      sec_buf_q     <= SEC_BUF_RESET;
      pri_buf_q     <= PRI_BUF_RESET;
      rsvd_q        <= RSVD_RESET;
      sel_q         <= SEL_RESET;
    end
    else if (wr_pend_q)
    begin
      if (wr_addr_q == ADDR_STATUS_PIN_EDGE_RATE)
      begin
        first_edge_q  <= hwdata[FIRST_EDGE_LSB +: 2];
        second_edge_q <= hwdata[SECOND_EDGE_LSB +: 2];
      end
      else if (wr_addr_q == ADDR_REFERENCE_INPUT_CONFIG)
      begin
        sec_buf_q <= hwdata[SEC_BUF_LSB +: 2];
        pri_buf_q <= hwdata[PRI_BUF_LSB +: 2];
        rsvd_q    <= hwdata[RSVD_LSB +: 2];
        sel_q     <= hwdata[SEL_LSB +: 2];
      end
    end
  end

  // Read data is registered at the end of the address phase.
  always_ff @(posedge clk)
  begin
    if (reset)
      hrdata_q <= 32'h0000_0000;
    else if (take && !hwrite)
    begin
      if (haddr[9:0] == ADDR_STATUS_PIN_EDGE_RATE)
        hrdata_q <= {28'h000_0000, second_edge_q, first_edge_q};
      else if (haddr[9:0] == ADDR_REFERENCE_INPUT_CONFIG)
        hrdata_q <= {24'h00_0000, sec_buf_q, pri_buf_q, rsvd_q, sel_q};
      else if (haddr[9:0] == ADDR_REFERENCE_STATUS)
        hrdata_q <= {29'h000_0000, choice_q};
      else
        hrdata_q <= 32'h0000_0000;
    end
  end

  ris_ref_decode u_decode (
    .clk          (clk),
    .reset        (reset),
    .sel_code     (sel_q),
    .pin_level    (reference_choice_pin),
    .ref_choice_q (choice_q)
  );

  // Registered pin and buffer controls.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      first_status_edge_rate  <= EDGE_RESET;
      second_status_edge_rate <= EDGE_RESET;
      first_status_slow       <= 1'b0;
      second_status_slow      <= 1'b0;
      primary_buffer_type     <= PRI_BUF_RESET;
      secondary_buffer_type   <= SEC_BUF_RESET;
      synth_reference_select  <= SEL_RESET;
      synth_reference_choice  <= RIS_REF_AUTO;
    end
    else
    begin
      first_status_edge_rate  <= first_edge_q;
      second_status_edge_rate <= second_edge_q;
      first_status_slow       <= edge_is_slow(first_edge_q);
      second_status_slow      <= edge_is_slow(second_edge_q);
      primary_buffer_type     <= pri_buf_q;
      secondary_buffer_type   <= sec_buf_q;
      synth_reference_select  <= sel_q;
      synth_reference_choice  <= choice_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata = hrdata_q;

endmodule // ris_regs

// >>> bench/ris_regs_asserts.sv
`timescale 1ns/10ps
module ris_regs_asserts
  import ris_pkg::*;
(
  // Clock and reset.
  input wire logic       clk,
  input wire logic       reset,
  // Watched pins.
  input wire logic [1:0] reference_choice_pin,
  input wire logic [1:0] first_status_edge_rate,
  input wire logic [1:0] second_status_edge_rate,
  input wire logic       first_status_slow,
  input wire logic       second_status_slow,
  input wire logic [1:0] primary_buffer_type,
  input wire logic [1:0] secondary_buffer_type,
  input wire logic [1:0] synth_reference_select,
  input wire logic [2:0] synth_reference_choice
);
  logic [1:0] rs_q;
  logic [1:0] sel_q;
  logic [1:0] pin_q;
  logic [1:0] pin_qq;
  always_ff @(posedge clk)
  begin
    rs_q   <= {rs_q[0], reset};
    sel_q  <= synth_reference_select;
    pin_q  <= reference_choice_pin;
    pin_qq <= pin_q;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_up; rs_q == 2'b00; endsequence
  sequence s_pin; s_up ##0 sel_q == SEL_PIN; endsequence
  sequence s_fixed; s_up ##0 sel_q != SEL_PIN; endsequence
  property p_slow0; first_status_slow == (first_status_edge_rate == EDGE_SLOW); endproperty
  a_slow0: assert property (p_slow0) else $error("first slow flag wrong");
  property p_slow1; second_status_slow == (second_status_edge_rate == EDGE_SLOW); endproperty
  a_slow1: assert property (p_slow1) else $error("second slow flag wrong");
  property p_edge_rst; rs_q[0] |-> {first_status_edge_rate, second_status_edge_rate} == 4'h0; endproperty
  a_edge_rst: assert property (p_edge_rst) else $error("edge rate reset wrong");
  property p_pri_rst; rs_q[0] |-> primary_buffer_type == PRI_BUF_RESET; endproperty
  a_pri_rst: assert property (p_pri_rst) else $error("primary buffer reset wrong");
  property p_sec_rst; rs_q[0] |-> secondary_buffer_type == SEC_BUF_RESET; endproperty
  a_sec_rst: assert property (p_sec_rst) else $error("secondary buffer reset wrong");
  property p_sel_rst; rs_q[0] |-> synth_reference_select == SEL_PIN; endproperty
  a_sel_rst: assert property (p_sel_rst) else $error("select reset wrong");
  property p_fixed;
    s_fixed |-> synth_reference_choice == (sel_q == SEL_AUTO ? RIS_REF_AUTO :
                sel_q == SEL_PRIMARY ? RIS_REF_PRIMARY : RIS_REF_SECOND);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed choice wrong");
  property p_pin;
    s_pin |-> synth_reference_choice == (pin_qq == PIN_LOW ? RIS_REF_PRIMARY :
              pin_qq == PIN_MID ? RIS_REF_SECOND : RIS_REF_AUTO);
  endproperty
  a_pin: assert property (p_pin) else $error("pin choice wrong");
endmodule // ris_regs_asserts

bind ris_regs ris_regs_asserts i_chk (.clk, .reset, .reference_choice_pin, .first_status_edge_rate,
  .second_status_edge_rate, .first_status_slow, .second_status_slow, .primary_buffer_type,
  .secondary_buffer_type, .synth_reference_select, .synth_reference_choice);

// >>> bench/ref_input_select_and_status_slew_regs_test.sv
`timescale 1ns/10ps
module ref_input_select_and_status_slew_regs_test
  import ris_pkg::*;
;
  logic        clk, reset, hwrite, hreadyout, hresp, dph, s0, s1;
  logic [1:0]  htrans, pin, e0, e1, pb, sb, sel, c0, c1;
  logic [2:0]  ch;
  logic [7:0]  cfg;
  logic [9:0]  addr;
  logic [31:0] hwdata, hrdata, exp_q[$];
  int          n_fail, n_checks;

  ris_regs i_dut (.clk, .reset, .hsel(1'b1), .haddr({22'h0, addr}), .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(hresp), .reference_choice_pin(pin),
    .first_status_edge_rate(e0), .second_status_edge_rate(e1), .first_status_slow(s0),
    .second_status_slow(s1), .primary_buffer_type(pb), .secondary_buffer_type(sb),
    .synth_reference_select(sel), .synth_reference_choice(ch));

  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task test_done;
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task bus(input logic [9:0] a, input logic w, input logic [31:0] d);
    addr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask

  task rd(input logic [9:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0000_0000);
  endtask

  function automatic logic [31:0] f_ch(input logic [1:0] s, input logic [1:0] q);
    logic [1:0] m;
    m = (s != SEL_PIN) ? s : (q == PIN_LOW) ? SEL_PRIMARY : (q == PIN_MID) ? SEL_SECOND : SEL_AUTO;
    return (m == SEL_AUTO) ? 32'h0000_0001 : (m == SEL_PRIMARY) ? 32'h0000_0002 : 32'h0000_0004;
  endfunction

  always @(posedge clk)
  begin
    if (dph === 1'b1 && hreadyout === 1'b1)
    begin
      chk(hrdata, exp_q.pop_front());
      chk({31'h0, hresp}, 32'h0000_0000);
    end
    dph <= htrans == HTRANS_NONSEQ && !hwrite && hreadyout;
  end

  initial
  begin
    reset = 1;
    htrans = 0;
    hwrite = 0;
    addr = 0;
    hwdata = 0;
    pin = 0;
    n_fail = 0;
    n_checks = 0;
    void'($urandom(32'h4376_3fec));
    repeat (6) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    rd(ADDR_STATUS_PIN_EDGE_RATE, 32'h0000_0000);
    rd(ADDR_REFERENCE_INPUT_CONFIG, 32'h0000_0095);
    chk({pb, sb, sel, ch}, {PRI_BUF_RESET, SEC_BUF_RESET, SEL_RESET, 3'h2});
    for (int i = 0; i < 4; i++)
    begin
      c0 = 2'($urandom_range(1)) << 1;
      c1 = 2'($urandom_range(1)) << 1;
      bus(ADDR_STATUS_PIN_EDGE_RATE, 1'b1, {28'h0, c1, c0});
      rd(ADDR_STATUS_PIN_EDGE_RATE, {28'h0, c1, c0});
      chk({e1, e0, s1, s0}, {c1, c0, c1[1], c0[1]});
      cfg = {i[1:0], i[1:0], 2'b01, i[1:0]};
      bus(ADDR_REFERENCE_INPUT_CONFIG, 1'b1, {24'h0, cfg});
      rd(ADDR_REFERENCE_INPUT_CONFIG, {24'h0, cfg});
      chk({sb, pb, sel}, {i[1:0], i[1:0], i[1:0]});
      for (int p = 0; p < 4; p++)
      begin
        pin <= p[1:0];
        repeat (4) @(posedge clk);
        chk(ch, f_ch(i[1:0], p[1:0]));
        rd(ADDR_REFERENCE_STATUS, f_ch(i[1:0], p[1:0]));
      end
    end
    bus(10'h100, 1'b1, $urandom);
    rd(10'h100, 32'h0000_0000);
    rd(ADDR_REFERENCE_INPUT_CONFIG, 32'h0000_00f7);
    rd(ADDR_STATUS_PIN_EDGE_RATE, {28'h0, c1, c0});
    reset <= 1;
    repeat (2) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    rd(ADDR_REFERENCE_INPUT_CONFIG, 32'h0000_0095);
    rd(ADDR_STATUS_PIN_EDGE_RATE, 32'h0000_0000);
    @(posedge clk);
    chk(exp_q.size(), 32'h0000_0000);
    test_done();
  end

  // Roughly thirteen times the expected run length.
  initial
  begin
    #20000;
    n_fail++;
    test_done();
  end
endmodule // ref_input_select_and_status_slew_regs_test
